// *** design/patl_pkg.sv ***
// Package: constants, register map and carrier types for the translation check unit
package patl_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int EA_W = 32;
  localparam int VA_W = 48;
  localparam int PCID_W = 8;
  localparam int PART_W = 6;
  localparam int RA_W = 36;
  localparam int L1_N = 4;
  localparam int L2_N = 8;
  localparam int L1_IW = 2;
  localparam int L2_IW = 3;
  localparam int ATTR_W = 5;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_PCID = 8'h00;
  localparam logic [7:0] OFF_PART = 8'h04;
  localparam logic [7:0] OFF_MSR = 8'h08;
  localparam logic [7:0] OFF_PRIV = 8'h0c;
  localparam logic [7:0] OFF_E_EPN = 8'h10;
  localparam logic [7:0] OFF_E_RPN = 8'h14;
  localparam logic [7:0] OFF_E_CTX = 8'h18;
  localparam logic [7:0] OFF_E_CMD = 8'h1c;
  localparam logic [7:0] OFF_INV = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  localparam logic [7:0] OFF_MASK = 8'h28;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int MSR_AS_BIT = 0;
  localparam int MSR_GS_BIT = 1;
  localparam int PRIV_SUP_BIT = 0;
  localparam int PRIV_HYP_BIT = 1;
  localparam int CMD_WR_BIT = 0;
  localparam int CMD_L2_BIT = 1;
  localparam int ST_MISS = 0;
  localparam int ST_PERM = 1;
  localparam int ST_TRAP = 2;
  localparam int ST_INV = 3;
  localparam int ST_W = 4;
  localparam logic [PART_W-1:0] PART_GLOBAL = 6'h00;
  localparam logic [1:0] PRIV_RST = 2'h2;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [4:0] SZ_4K = 5'h00;
  localparam logic [4:0] SZ_MAX = 5'h14;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef enum logic [1:0] {
    ACC_READ = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_EXEC = 2'b10
  } patl_acc_t;

  typedef enum logic [1:0] {
    RES_OK = 2'b00,
    RES_MISS = 2'b01,
    RES_PERM = 2'b10
  } patl_res_t;

  // Attributes: cache inhibit, coherent, guarded, write-through, little endian
  typedef struct packed {
    logic valid;
    logic [4:0] size;
    logic [19:0] epn;
    logic [PCID_W-1:0] pcid;
    logic as_bit;
    logic [PART_W-1:0] part_tag;
    logic guest_flag;
    logic [5:0] perm;
    logic [ATTR_W-1:0] attr;
    logic [23:0] rpn;
  } patl_entry_t;

  typedef struct packed {
    logic [EA_W-1:0] effective_address;
    patl_acc_t acc;
  } patl_req_t;

  typedef struct packed {
    patl_res_t res;
    logic [RA_W-1:0] real_address;
    logic [ATTR_W-1:0] attr;
  } patl_rsp_t;

endpackage

// *** design/patl_tlb.sv ***
// Two-level partition-aware translation and protection unit
`timescale 1ns/1ps

// Functional notes
// - Two-level TLB, always on, no bypass
// - Extend 32-bit address to 48-bit virtual
// - Process id 8 bits, partition 6 bits
// - Space and guest bits from machine state
// - Fixed 4KB and variable pages matched together
// - Entries carry translation and attributes out
// - Check access type, privilege and context
// - Partition tag must equal current partition
// - Partition tag zero matches any partition
// - Guest state uses only guest entries
// - Supervisor/user permission filtering applied
// - Only hypervisor may write entries
// - Guest entry write suppressed and trapped
// - Broadcast invalidate honours full context
// - Partition register rewritable at run time
module patl_tlb
  import patl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Translation request and answer
  input wire logic req_valid,
  input wire patl_req_t req,
  output logic rsp_valid,
  output patl_rsp_t rsp,
  // Invalidate broadcast in and out
  input wire logic inv_in_valid,
  input wire logic [VA_W-1:0] inv_in_va,
  output logic inv_out_valid,
  output logic [VA_W-1:0] inv_out_va,
  // Events
  output logic trap_q,
  output logic irq
);

  // ****************************************************************
  // Context registers
  // ****************************************************************
  logic [PCID_W-1:0] pcid_q;
  logic [PART_W-1:0] part_q;
  logic [1:0] msr_q;
  logic [1:0] priv_q;
  logic [31:0] e_epn_q, e_rpn_q, e_ctx_q;
  logic [ST_W-1:0] stat_q, mask_q;
  logic bus_ack_q;
  logic hyp, sup, gs_bit, as_bit;
  assign hyp = priv_q[PRIV_HYP_BIT] && !msr_q[MSR_GS_BIT];
  assign sup = priv_q[PRIV_SUP_BIT] || hyp;
  assign gs_bit = msr_q[MSR_GS_BIT];
  assign as_bit = msr_q[MSR_AS_BIT];

  logic wr_acc, rd_acc;
  // Write lands on the edge that shows waitrequest low
  assign wr_acc = avs_write && bus_ack_q;
  assign rd_acc = avs_read && !bus_ack_q;

  // One wait state per access
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= (avs_read || avs_write) && !bus_ack_q;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !bus_ack_q);
    end
  end

  logic do_wr;
  assign do_wr = wr_acc && !avs_waitrequest;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pcid_q <= '0;
      part_q <= '0;
      msr_q <= '0;
      priv_q <= PRIV_RST;
      e_epn_q <= '0;
      e_rpn_q <= '0;
      e_ctx_q <= '0;
      mask_q <= '0;
    end else if (do_wr) begin
      if (avs_address == OFF_PCID && sup) begin
        pcid_q <= avs_writedata[PCID_W-1:0];
      end else if (avs_address == OFF_PART && hyp) begin
        part_q <= avs_writedata[PART_W-1:0];
      end else if (avs_address == OFF_MSR) begin
        msr_q <= avs_writedata[1:0];
      end else if (avs_address == OFF_PRIV) begin
        priv_q <= avs_writedata[1:0];
      end else if (avs_address == OFF_E_EPN) begin
        e_epn_q <= avs_writedata;
      end else if (avs_address == OFF_E_RPN) begin
        e_rpn_q <= avs_writedata;
      end else if (avs_address == OFF_E_CTX) begin
        e_ctx_q <= avs_writedata;
      end else if (avs_address == OFF_MASK) begin
        mask_q <= avs_writedata[ST_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Entry arrays
  // ****************************************************************
  patl_entry_t l1_q [L1_N];
  patl_entry_t l2_q [L2_N];
  patl_entry_t new_e;
  logic e_write, e_trap, inv_local;
  logic [VA_W-1:0] inv_va;
  assign new_e = '{valid: e_ctx_q[31], size: e_epn_q[4:0], epn: e_epn_q[31:12],
                   pcid: e_ctx_q[7:0], as_bit: e_ctx_q[8], part_tag: e_ctx_q[14:9],
                   guest_flag: e_ctx_q[15], perm: e_ctx_q[21:16],
                   attr: e_rpn_q[4:0], rpn: {e_ctx_q[27:24], e_rpn_q[31:12]}};
  assign e_write = do_wr && avs_address == OFF_E_CMD && avs_writedata[CMD_WR_BIT] && hyp;
  assign e_trap = do_wr && avs_address == OFF_E_CMD && avs_writedata[CMD_WR_BIT] && gs_bit;
  assign inv_local = do_wr && avs_address == OFF_INV && !gs_bit;
  // Local invalidate carries the full virtual context
  assign inv_va = inv_local ? {part_q, gs_bit, as_bit, pcid_q, avs_writedata} : inv_in_va;

  function automatic logic inv_hit(patl_entry_t e, logic [VA_W-1:0] va);
    inv_hit = e.valid && e.epn == va[31:12] && e.pcid == va[39:32] && e.as_bit == va[40]
              && e.guest_flag == va[41] && e.part_tag == va[47:42];
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < L1_N; i++) begin
        l1_q[i] <= '0;
      end
      for (int i = 0; i < L2_N; i++) begin
        l2_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < L1_N; i++) begin
        if ((inv_local || inv_in_valid) && inv_hit(l1_q[i], inv_va)) begin
          l1_q[i].valid <= 1'b0;
        end
      end
      for (int i = 0; i < L2_N; i++) begin
        if ((inv_local || inv_in_valid) && inv_hit(l2_q[i], inv_va)) begin
          l2_q[i].valid <= 1'b0;
        end
      end
      if (e_write && !avs_writedata[CMD_L2_BIT]) begin
        l1_q[avs_writedata[L1_IW+7:8]] <= '{valid: new_e.valid, size: SZ_4K, epn: new_e.epn,
            pcid: new_e.pcid, as_bit: new_e.as_bit, part_tag: new_e.part_tag,
            guest_flag: new_e.guest_flag, perm: new_e.perm, attr: new_e.attr,
            rpn: new_e.rpn};
      end else if (e_write) begin
        l2_q[avs_writedata[L2_IW+7:8]] <= new_e;
      end
    end
  end

  // Broadcast out the local invalidate to other cores
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      inv_out_valid <= 1'b0;
      inv_out_va <= '0;
    end else begin
      inv_out_valid <= inv_local;
      inv_out_va <= inv_local ? inv_va : inv_out_va;
    end
  end

  // ****************************************************************
  // Lookup
  // ****************************************************************
  logic [VA_W-1:0] va;
  assign va = {part_q, gs_bit, as_bit, pcid_q, req.effective_address};

  function automatic logic ent_hit(patl_entry_t e, logic [VA_W-1:0] v);
    logic [31:0] m;
    logic [4:0] sz;
    sz = (e.size > SZ_MAX) ? SZ_MAX : e.size;
    m = 32'hffff_ffff << (6'd12 + {1'b0, sz});
    ent_hit = e.valid && ((e.epn & m[31:12]) == (v[31:12] & m[31:12]))
              && e.pcid == v[39:32] && e.as_bit == v[40]
              && (e.part_tag == v[47:42] || e.part_tag == PART_GLOBAL)
              && e.guest_flag == v[41];
  endfunction

  patl_entry_t hit_e;
  logic hit;
  always_comb begin
    hit = 1'b0;
    hit_e = '0;
    // Both levels searched in parallel; first level wins
    for (int i = L2_N - 1; i >= 0; i--) begin
      if (ent_hit(l2_q[i], va)) begin
        hit = 1'b1;
        hit_e = l2_q[i];
      end
    end
    for (int i = L1_N - 1; i >= 0; i--) begin
      if (ent_hit(l1_q[i], va)) begin
        hit = 1'b1;
        hit_e = l1_q[i];
      end
    end
  end

  // Perm bits: [5:3] supervisor rwx, [2:0] user rwx
  logic [2:0] rwx;
  logic allow;
  always_comb begin
    rwx = sup ? hit_e.perm[5:3] : hit_e.perm[2:0];
    case (req.acc)
      ACC_READ: allow = rwx[2];
      ACC_WRITE: allow = rwx[1];
      ACC_EXEC: allow = rwx[0];
      default: allow = 1'b0;
    endcase
  end

  logic [31:0] pmask;
  assign pmask = 32'hffff_ffff << (6'd12 + {1'b0, (hit_e.size > SZ_MAX) ? SZ_MAX : hit_e.size});

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        if (!hit) begin
          rsp <= '{res: RES_MISS, real_address: '0, attr: '0};
        end else if (!allow) begin
          rsp <= '{res: RES_PERM, real_address: '0, attr: '0};
        end else begin
          rsp <= '{res: RES_OK,
                   real_address: ({hit_e.rpn, 12'h000} & {4'hf, pmask})
                                 | {4'h0, req.effective_address & ~pmask},
                   attr: hit_e.attr};
        end
      end
    end
  end

  // ****************************************************************
  // Status, interrupt, trap and read-back
  // ****************************************************************
  logic [ST_W-1:0] ev;
  assign ev = {inv_in_valid, e_trap, req_valid && hit && !allow, req_valid && !hit};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      // Set wins over write-one-to-clear
      stat_q <= (stat_q & ~((do_wr && avs_address == OFF_STAT) ? avs_writedata[ST_W-1:0] : '0))
                | ev;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
      trap_q <= 1'b0;
    end else begin
      irq <= |((stat_q | ev) & mask_q);
      trap_q <= e_trap;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (rd_acc) begin
      if (avs_address == OFF_PCID) begin
        avs_readdata <= {24'h000000, pcid_q};
      end else if (avs_address == OFF_PART) begin
        avs_readdata <= {26'h0000000, part_q};
      end else if (avs_address == OFF_MSR) begin
        avs_readdata <= {30'h00000000, msr_q};
      end else if (avs_address == OFF_PRIV) begin
        avs_readdata <= {30'h00000000, priv_q};
      end else if (avs_address == OFF_E_EPN) begin
        avs_readdata <= e_epn_q;
      end else if (avs_address == OFF_E_RPN) begin
        avs_readdata <= e_rpn_q;
      end else if (avs_address == OFF_E_CTX) begin
        avs_readdata <= e_ctx_q;
      end else if (avs_address == OFF_STAT) begin
        avs_readdata <= {28'h0000000, stat_q};
      end else if (avs_address == OFF_MASK) begin
        avs_readdata <= {28'h0000000, mask_q};
      end else begin
        avs_readdata <= RD_UNMAPPED;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_bcast_pulse;
    inv_out_valid ##1 !inv_out_valid;
  endsequence

  a_miss_blocks: assert property (@(posedge clock) disable iff (!rstn)
    req_valid && !hit |=> rsp_valid && rsp.res == RES_MISS && rsp.real_address == '0)
    else $error("miss not reported");
  a_guest_trap: assert property (@(posedge clock) disable iff (!rstn)
    e_trap |=> trap_q && stat_q[ST_TRAP]) else $error("guest entry write not trapped");
  a_guest_nowrite: assert property (@(posedge clock) disable iff (!rstn)
    gs_bit |-> !e_write) else $error("entry written from guest");
  a_part_guard: assert property (@(posedge clock) disable iff (!rstn)
    do_wr && avs_address == OFF_PART && !hyp |=> $stable(part_q))
    else $error("partition written without hypervisor");
  a_part_update: assert property (@(posedge clock) disable iff (!rstn)
    do_wr && avs_address == OFF_PART && hyp |=> part_q == $past(avs_writedata[PART_W-1:0]))
    else $error("partition not updated");
  a_pcid_guard: assert property (@(posedge clock) disable iff (!rstn)
    do_wr && avs_address == OFF_PCID && !sup |=> $stable(pcid_q))
    else $error("process id written without supervisor");
  a_guest_only: assert property (@(posedge clock) disable iff (!rstn)
    hit |-> hit_e.guest_flag == gs_bit) else $error("guest flag mismatch");
  a_part_match: assert property (@(posedge clock) disable iff (!rstn)
    hit |-> hit_e.part_tag == part_q || hit_e.part_tag == PART_GLOBAL)
    else $error("partition mismatch hit");
  a_inv_bcast: assert property (@(posedge clock) disable iff (!rstn)
    inv_local |=> s_bcast_pulse) else $error("invalidate not sent");
  a_perm_deny: assert property (@(posedge clock) disable iff (!rstn)
    req_valid && hit && !allow |=> rsp.res == RES_PERM) else $error("permission not denied");
  a_perm_status: assert property (@(posedge clock) disable iff (!rstn)
    req_valid && hit && !allow |=> stat_q[ST_PERM]) else $error("permission fault not recorded");
  a_ok_attr: assert property (@(posedge clock) disable iff (!rstn)
    req_valid && hit && allow |=> rsp.res == RES_OK && rsp.attr == $past(hit_e.attr))
    else $error("attributes not passed on");

endmodule

// *** dv/patl_core_model.sv ***
// Core pipeline model issuing translations and remote invalidates
`timescale 1ns/1ps
module patl_core_model
  import patl_pkg::*;
(
  // Clock
  input wire logic clock,
  // Translation side
  output logic req_valid,
  output patl_req_t req,
  input wire logic rsp_valid,
  input wire patl_rsp_t rsp,
  // Broadcast side
  output logic inv_in_valid,
  output logic [VA_W-1:0] inv_in_va
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    inv_in_valid = 1'b0;
    inv_in_va = '0;
  end

  // One request; the answer is taken two edges after it
  task automatic access(input logic [EA_W-1:0] ea, input patl_acc_t acc,
                        output patl_rsp_t r, output logic ok);
    begin
      req_valid <= 1'b1;
      req <= '{effective_address: ea, acc: acc};
      @(posedge clock);
      req_valid <= 1'b0;
      req <= '{effective_address: ~ea, acc: ACC_EXEC};
      @(posedge clock);
      ok = rsp_valid;
      r = rsp;
    end
  endtask

  // Invalidate arriving from another core of the domain
  task automatic bcast(input logic [VA_W-1:0] va);
    begin
      inv_in_valid <= 1'b1;
      inv_in_va <= va;
      @(posedge clock);
      inv_in_valid <= 1'b0;
      inv_in_va <= ~va;
      @(posedge clock);
    end
  endtask
endmodule

// *** dv/patl_tlb_tb_top.sv ***
// Self-checking bench for the translation check unit
`timescale 1ns/1ps
module patl_tlb_tb_top
  import patl_pkg::*;
;
  logic clock, rstn, avs_read, avs_write, avs_waitrequest, req_valid, rsp_valid;
  logic inv_in_valid, inv_out_valid, trap_q, irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [VA_W-1:0] inv_in_va, inv_out_va, inv_va_q;
  patl_req_t req;
  patl_rsp_t rsp;
  int miscompares, tests_run, cycles, trap_seen, inv_seen;

  patl_tlb dut (.clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .inv_in_valid(inv_in_valid), .inv_in_va(inv_in_va),
    .inv_out_valid(inv_out_valid), .inv_out_va(inv_out_va), .trap_q(trap_q), .irq(irq));
  patl_core_model core (.clock(clock), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .inv_in_valid(inv_in_valid), .inv_in_va(inv_in_va));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (trap_q === 1'b1) trap_seen++;
    if (inv_out_valid === 1'b1) begin
      inv_seen++;
      inv_va_q = inv_out_va;
    end
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        miscompares++;
        $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= ~rd;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) begin
        @(posedge clock);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    begin
      bus(1'b1, a, 32'h0000_0000, q);
      check("readdata", q, exp);
    end
  endtask

  task automatic ent(input logic [2:0] idx, input logic l2, input logic [31:0] epn,
                     input logic [31:0] rpn, input logic [31:0] ctx);
    begin
      wr(OFF_E_EPN, epn);
      wr(OFF_E_RPN, rpn);
      wr(OFF_E_CTX, ctx);
      wr(OFF_E_CMD, {21'h0, idx, 6'h0, l2, 1'b1});
    end
  endtask

  task automatic xl(input logic [31:0] ea, input patl_acc_t acc, input patl_res_t er,
                    input logic [35:0] ra, input logic [4:0] at);
    patl_rsp_t r;
    logic ok;
    begin
      core.access(ea, acc, r, ok);
      check("rsp_valid", ok, 1'b1);
      check("rsp.res", r.res, er);
      check("rsp.real_address", r.real_address, ra);
      check("rsp.attr", r.attr, at);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    begin
      rdc(OFF_PRIV, {30'h0, PRIV_RST});
      rdc(OFF_MSR, 32'h0000_0000);
      rdc(8'hfc, RD_UNMAPPED);
      xl(32'h1234_5678, ACC_READ, RES_MISS, 36'h0, 5'h00);
      check("irq", irq, 1'b0);
      $display("test reset done");
    end
  endtask

  task automatic t_hit;
    begin
      wr(OFF_PCID, 32'h0000_0012);
      wr(OFF_PART, 32'h0000_0005);
      wr(OFF_PRIV, 32'h0000_0003);
      ent(3'h0, 1'b0, 32'h1234_5000, 32'habcd_e015, 32'h873f_0a12);
      xl(32'h1234_5678, ACC_READ, RES_OK, 36'h7_abcd_e678, 5'h15);
      wr(OFF_MSR, 32'h0000_0001);
      xl(32'h1234_5678, ACC_READ, RES_MISS, 36'h0, 5'h00);
      wr(OFF_MSR, 32'h0000_0000);
      wr(OFF_PCID, 32'h0000_0013);
      xl(32'h1234_5678, ACC_WRITE, RES_MISS, 36'h0, 5'h00);
      wr(OFF_PCID, 32'h0000_0012);
      $display("test hit done");
    end
  endtask

  task automatic t_part;
    begin
      wr(OFF_PART, 32'h0000_0006);
      rdc(OFF_PART, 32'h0000_0006);
      xl(32'h1234_5678, ACC_READ, RES_MISS, 36'h0, 5'h00);
      ent(3'h1, 1'b0, 32'h2222_2000, 32'h1111_1000, 32'h803f_0012);
      xl(32'h2222_2004, ACC_EXEC, RES_OK, 36'h0_1111_1004, 5'h00);
      wr(OFF_PART, 32'h0000_0005);
      xl(32'h1234_5678, ACC_EXEC, RES_OK, 36'h7_abcd_e678, 5'h15);
      $display("test partition done");
    end
  endtask

  task automatic t_page;
    begin
      ent(3'h2, 1'b1, 32'h4000_0004, 32'h5000_0000, 32'h803f_0a12);
      xl(32'h4000_abcd, ACC_READ, RES_OK, 36'h0_5000_abcd, 5'h00);
      xl(32'h4001_0000, ACC_READ, RES_MISS, 36'h0, 5'h00);
      $display("test page size done");
    end
  endtask

  task automatic t_perm;
    begin
      ent(3'h3, 1'b0, 32'h3333_3000, 32'h3333_3000, 32'h8000_0a12);
      wr(OFF_STAT, 32'h0000_000f);
      for (int a = 0; a < 3; a++) begin
        xl(32'h3333_3010, patl_acc_t'(a), RES_PERM, 36'h0, 5'h00);
      end
      rdc(OFF_STAT, 32'h0000_0002);
      $display("test permission done");
    end
  endtask

  task automatic t_guest;
    patl_rsp_t r;
    logic ok;
    begin
      ent(3'h3, 1'b0, 32'h3333_3000, 32'h3333_3000, 32'h803f_8a12);
      wr(OFF_STAT, 32'h0000_000f);
      wr(OFF_MSR, 32'h0000_0002);
      core.access(32'h1234_5678, ACC_READ, r, ok);
      check("guest on host page", r.res == RES_OK, 1'b0);
      xl(32'h3333_3020, ACC_READ, RES_OK, 36'h0_3333_3020, 5'h00);
      wr(OFF_PART, 32'h0000_0009);
      wr(OFF_E_CMD, 32'h0000_0001);
      repeat (2) @(posedge clock);
      check("trap pulses", trap_seen, 1);
      rdc(OFF_STAT, 32'h0000_0005);
      wr(OFF_MSR, 32'h0000_0000);
      rdc(OFF_PART, 32'h0000_0005);
      xl(32'h1234_5678, ACC_READ, RES_OK, 36'h7_abcd_e678, 5'h15);
      wr(OFF_PRIV, 32'h0000_0000);
      wr(OFF_PCID, 32'h0000_0044);
      wr(OFF_PRIV, 32'h0000_0003);
      rdc(OFF_PCID, 32'h0000_0012);
      $display("test guest done");
    end
  endtask

  task automatic t_inv;
    begin
      core.bcast({6'h09, 2'b00, 8'h12, 32'h1234_5000});
      xl(32'h1234_5678, ACC_READ, RES_OK, 36'h7_abcd_e678, 5'h15);
      core.bcast({6'h05, 2'b00, 8'h12, 32'h4000_0000});
      xl(32'h4000_abcd, ACC_READ, RES_MISS, 36'h0, 5'h00);
      rdc(OFF_STAT, 32'h0000_000d);
      wr(OFF_INV, 32'h1234_5000);
      repeat (2) @(posedge clock);
      check("inv_out pulses", inv_seen, 1);
      check("inv_out_va", inv_va_q, {6'h05, 2'b00, 8'h12, 32'h1234_5000});
      $display("test invalidate done");
    end
  endtask

  task automatic t_irq;
    begin
      wr(OFF_STAT, 32'h0000_000f);
      wr(OFF_MASK, 32'h0000_0001);
      rdc(OFF_MASK, 32'h0000_0001);
      xl(32'h2222_2000, ACC_WRITE, RES_OK, 36'h0_1111_1000, 5'h00);
      ent(3'h3, 1'b0, 32'h3333_3000, 32'h3333_3000, 32'h8000_0a12);
      xl(32'h3333_3000, ACC_WRITE, RES_PERM, 36'h0, 5'h00);
      check("irq masked", irq, 1'b0);
      xl(32'h7777_7000, ACC_READ, RES_MISS, 36'h0, 5'h00);
      check("irq raised", irq, 1'b1);
      wr(OFF_STAT, 32'h0000_0001);
      repeat (2) @(posedge clock);
      check("irq cleared", irq, 1'b0);
      rdc(OFF_STAT, 32'h0000_0002);
      $display("test interrupt done");
    end
  endtask

  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_hit();
    t_part();
    t_page();
    t_perm();
    t_guest();
    t_inv();
    t_irq();
    end_of_test();
  end
endmodule
